/* File: rtl/ctmr_top.sv */
// Purpose: 8-bit clock timer with tap interrupts, APB slave
// Assumes: APB master on I_REF_CLK, zero wait beyond one access cycle
// Notes:   256 Hz tick enable from a divider stands in for the oscillator
//
// Summary of operation
// - Eight-bit up-counter advanced by the 256 Hz divided tick.
// - Low nibble overflow carries into the high nibble.
// - Low nibble is 128..16 Hz taps, high nibble 8..1 Hz taps.
// - Count nibbles are read-only; writes to them are ignored.
// - Reading low nibble freezes high nibble until high read or window ends.
// - Control bit 1 written one clears count; reads zero.
// - Clear while running restarts at once; while stopped stays zero.
// - Control bit 0 runs or stops counting; readable, resets zero.
// - Stopped count holds and resumes from held value.
// - Falling edges of 32, 8, 2, 1 Hz taps set flags.
// - Flags set regardless of enable bits.
// - Enable register bits 0..3 for 32, 8, 2, 1 Hz, reset zero.
// - Flag register bits 0..3 for 32, 8, 2, 1 Hz, reset zero.
// - Writing one clears a flag; zero leaves it.
// - Reset clears count, run, enables and flags.
//
// The implementer's own choice: register access over APB.
`include "ctmr_defs.svh"
`default_nettype none
module ctmr_top #(
  parameter logic [17:0] TICK_CYC = 18'(`CT_TICK_CYC),
  parameter logic [17:0] HOLD_CYC = 18'(`CT_HOLD_CYC)
) (
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RSTN,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [17:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Interrupt
  output logic             O_IRQ
);

  logic [17:0]         pre_q;
  logic [17:0]         pre_d;
  logic [17:0]         hcnt_q;
  logic [17:0]         hcnt_d;
  logic [3:0]          cnt_lo_q;
  logic [3:0]          cnt_lo_d;
  logic [3:0]          cnt_hi_q;
  logic [3:0]          cnt_hi_d;
  logic                run_q;
  logic                run_d;
  logic                pend_q;
  logic                pend_d;
  logic [3:0]          ien_q;
  logic [3:0]          ien_d;
  logic [3:0]          flg_q;
  logic [3:0]          flg_d;
  logic [3:0]          tap_q;
  logic                rdy_q;
  logic                irq_q;
  logic [31:0]         rdata_q;
  logic                slverr_q;
  ctmr_pkg::ctmr_hold_t hold_q;
  ctmr_pkg::ctmr_hold_t hold_d;

  // APB decode
  wire [15:0] idx_w     = I_PADDR[17:2];
  wire        setup_w   = I_PSEL & ~I_PENABLE;
  wire        acc_w     = I_PSEL & I_PENABLE & rdy_q;
  wire        wr_w      = acc_w & I_PWRITE;
  wire        rd_w      = acc_w & ~I_PWRITE;
  wire        sel_ctrl  = (idx_w == `CT_IDX_CTRL);
  wire        sel_lo    = (idx_w == `CT_IDX_LO);
  wire        sel_hi    = (idx_w == `CT_IDX_HI);
  wire        sel_ien   = (idx_w == `CT_IDX_IEN);
  wire        sel_iflg  = (idx_w == `CT_IDX_IFLG);
  wire        mapped_w  = sel_ctrl | sel_lo | sel_hi | sel_ien | sel_iflg;
  wire        wr_ctrl   = wr_w & sel_ctrl;
  wire        wr_ien    = wr_w & sel_ien;
  wire        wr_iflg   = wr_w & sel_iflg;
  wire        rd_lo     = rd_w & sel_lo;
  wire        rd_hi     = rd_w & sel_hi;
  wire        lo_pick_w = setup_w & ~I_PWRITE & sel_lo;

  // Clear pulse; bit itself is never stored
  wire        clr_w     = wr_ctrl & I_PWDATA[`CT_CTRL_CLR_BIT];

  // Read data; unused control bits and reserved bits stay zero
  wire [3:0]  ctrl_rd_w = {3'h0, run_q};
  wire [3:0]  nib_rd_w  = sel_ctrl ? ctrl_rd_w :
                          sel_lo   ? cnt_lo_q  :
                          sel_hi   ? cnt_hi_q  :
                          sel_ien  ? ien_q     :
                          sel_iflg ? flg_q     : 4'h0;

  // Prescaler: divided tick stands in for the oscillator clock
  wire        tick_w    = (pre_q == TICK_CYC - 18'h00001);
  assign pre_d = (clr_w | tick_w) ? 18'h00000 : pre_q + 18'h00001;

  // Counter steps
  wire        hold_on   = (hold_q == ctmr_pkg::CT_HOLD_ON);
  // Low nibble is captured at setup, so a carry in that cycle must wait too
  wire        hold_blk  = hold_on | lo_pick_w;
  wire        inc_lo    = tick_w & run_q & ~clr_w;
  wire        carry_w   = inc_lo & (cnt_lo_q == 4'hF);
  wire        inc_hi    = (carry_w | pend_q) & ~hold_blk & ~clr_w;

  // Clear wins over counting; stopped counter keeps zero
  assign cnt_lo_d = clr_w  ? `CT_RST_NIB :
                    inc_lo ? cnt_lo_q + 4'h1 : cnt_lo_q;
  assign cnt_hi_d = clr_w  ? `CT_RST_NIB :
                    inc_hi ? cnt_hi_q + 4'h1 : cnt_hi_q;

  // At most one carry can fall inside the short hold window
  assign pend_d = clr_w              ? 1'b0 :
                  carry_w & hold_blk ? 1'b1 :
                  ~hold_blk          ? 1'b0 : pend_q;

  assign run_d  = wr_ctrl ? I_PWDATA[`CT_CTRL_RUN_BIT] : run_q;
  assign ien_d  = wr_ien  ? I_PWDATA[3:0] : ien_q;

  // Hold window timer
  wire        hold_end  = (hcnt_q == HOLD_CYC - 18'h00001);

  always_comb begin
    hold_d = hold_q;
    hcnt_d = hcnt_q;
    case (hold_q)
      ctmr_pkg::CT_HOLD_OFF: begin
        hcnt_d = 18'h00000;
        if (lo_pick_w && !clr_w) begin
          hold_d = ctmr_pkg::CT_HOLD_ON;
        end
      end
      ctmr_pkg::CT_HOLD_ON: begin
        hcnt_d = hcnt_q + 18'h00001;
        // A fresh low read restarts the window even on its last cycle
        if (clr_w || rd_hi) begin
          hold_d = ctmr_pkg::CT_HOLD_OFF;
          hcnt_d = 18'h00000;
        end else if (lo_pick_w) begin
          hcnt_d = 18'h00000;
        end else if (hold_end) begin
          hold_d = ctmr_pkg::CT_HOLD_OFF;
          hcnt_d = 18'h00000;
        end
      end
      default: begin
        hold_d = ctmr_pkg::CT_HOLD_OFF;
        hcnt_d = 18'h00000;
      end
    endcase
  end

  // Taps: 32 Hz, 8 Hz, 2 Hz, 1 Hz
  wire [3:0]  taps_w    = {cnt_hi_q[3], cnt_hi_q[2], cnt_hi_q[0], cnt_lo_q[2]};
  wire [3:0]  fall_w    = tap_q & ~taps_w;

  // Set beats clear in the same cycle
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_flag
      assign flg_d[k] = fall_w[k] | (flg_q[k] & ~(wr_iflg & I_PWDATA[k]));
    end
  endgenerate

  // Registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      pre_q    <= 18'h00000;
      hcnt_q   <= 18'h00000;
      cnt_lo_q <= `CT_RST_NIB;
      cnt_hi_q <= `CT_RST_NIB;
      run_q    <= `CT_RST_RUN;
      pend_q   <= 1'b0;
      ien_q    <= `CT_RST_NIB;
      flg_q    <= `CT_RST_NIB;
      tap_q    <= 4'h0;
      hold_q   <= ctmr_pkg::CT_HOLD_OFF;
    end else begin
      pre_q    <= pre_d;
      hcnt_q   <= hcnt_d;
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
      run_q    <= run_d;
      pend_q   <= pend_d;
      ien_q    <= ien_d;
      flg_q    <= flg_d;
      tap_q    <= taps_w;
      hold_q   <= hold_d;
    end
  end

  // Bus answer registered in setup, so pready rises in the access cycle
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      rdy_q    <= 1'b0;
      rdata_q  <= 32'h00000000;
      slverr_q <= 1'b0;
    end else begin
      rdy_q    <= setup_w;
      rdata_q  <= setup_w ? {28'h0000000, nib_rd_w} : 32'h00000000;
      slverr_q <= setup_w & ~mapped_w;
    end
  end

  // Level interrupt, one cycle behind the flags
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flg_q & ien_q);
    end
  end

  assign O_PREADY  = rdy_q;
  assign O_PRDATA  = rdata_q;
  assign O_PSLVERR = slverr_q;
  assign O_IRQ     = irq_q;

  // Checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  property p_stop_holds;
    !run_q && !clr_w |=> $stable(cnt_lo_q);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("count moved while stopped");

  property p_clear;
    clr_w |=> (cnt_lo_q == 4'h0) && (cnt_hi_q == 4'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero count");

  property p_ro;
    wr_w && (sel_lo || sel_hi) && !tick_w && !pend_q |=> $stable(cnt_lo_q) && $stable(cnt_hi_q);
  endproperty
  a_ro: assert property (p_ro) else $error("write changed count");

  sequence s_lo_read;
    lo_pick_w && !clr_w;
  endsequence
  sequence s_hi_frozen;
    hold_on && $stable(cnt_hi_q);
  endsequence
  property p_hold;
    s_lo_read |=> s_hi_frozen;
  endproperty
  a_hold: assert property (p_hold) else $error("high nibble not held");

  property p_hi_frozen;
    hold_blk && !clr_w |=> $stable(cnt_hi_q);
  endproperty
  a_hi_frozen: assert property (p_hi_frozen) else $error("high nibble moved in hold");

  property p_lo_access_held;
    rd_lo |-> hold_on;
  endproperty
  a_lo_access_held: assert property (p_lo_access_held) else $error("hold not open at low read");

  property p_hold_bound;
    hold_on |-> hcnt_q < HOLD_CYC;
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("hold window overrun");

  property p_carry;
    carry_w && !hold_blk |=> cnt_hi_q == $past(cnt_hi_q) + 4'h1;
  endproperty
  a_carry: assert property (p_carry) else $error("carry lost");

  property p_flag_set;
    fall_w[0] |=> flg_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("32 Hz flag not set");

  property p_w1c;
    wr_iflg && I_PWDATA[3] && !fall_w[3] |=> !flg_q[3];
  endproperty
  a_w1c: assert property (p_w1c) else $error("1 Hz flag not cleared");

  property p_irq;
    |(flg_q & ien_q) |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_no_irq;
    (flg_q & ien_q) == 4'h0 |=> !O_IRQ;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("spurious interrupt");

  property p_ctrl_rd;
    setup_w && sel_ctrl |=> O_PRDATA[31:1] == 31'h00000000 && O_PREADY;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control upper bits not zero");

  property p_run_set;
    wr_ctrl |=> run_q == $past(I_PWDATA[`CT_CTRL_RUN_BIT]);
  endproperty
  a_run_set: assert property (p_run_set) else $error("run bit not stored");

  property p_run_step;
    run_q && tick_w && !clr_w |=> cnt_lo_q == $past(cnt_lo_q) + 4'h1;
  endproperty
  a_run_step: assert property (p_run_step) else $error("count did not step");

  property p_stop_hi;
    !run_q && !clr_w && !pend_q |=> $stable(cnt_hi_q);
  endproperty
  a_stop_hi: assert property (p_stop_hi) else $error("high nibble moved while stopped");

  property p_carry_only;
    !carry_w && !pend_q && !clr_w |=> $stable(cnt_hi_q);
  endproperty
  a_carry_only: assert property (p_carry_only) else $error("high nibble moved without carry");

  property p_pend_apply;
    pend_q && !hold_blk && !clr_w |=> cnt_hi_q == $past(cnt_hi_q) + 4'h1;
  endproperty
  a_pend_apply: assert property (p_pend_apply) else $error("held carry not applied");

  property p_ien_wr;
    wr_ien |=> ien_q == $past(I_PWDATA[3:0]);
  endproperty
  a_ien_wr: assert property (p_ien_wr) else $error("enable write lost");

  // Read path
  property p_lo_rd;
    setup_w && sel_lo |=> O_PRDATA[3:0] == $past(cnt_lo_q);
  endproperty
  a_lo_rd: assert property (p_lo_rd) else $error("low nibble read wrong");

  property p_hi_rd;
    setup_w && sel_hi |=> O_PRDATA[3:0] == $past(cnt_hi_q);
  endproperty
  a_hi_rd: assert property (p_hi_rd) else $error("high nibble read wrong");

  // Per-tap flags
  property p_flag_set_8hz;
    fall_w[1] |=> flg_q[1];
  endproperty
  a_flag_set_8hz: assert property (p_flag_set_8hz) else $error("8 Hz flag not set");

  property p_flag_set_2hz;
    fall_w[2] |=> flg_q[2];
  endproperty
  a_flag_set_2hz: assert property (p_flag_set_2hz) else $error("2 Hz flag not set");

  property p_flag_set_1hz;
    fall_w[3] |=> flg_q[3];
  endproperty
  a_flag_set_1hz: assert property (p_flag_set_1hz) else $error("1 Hz flag not set");

  property p_no_false_set;
    !fall_w[0] && !flg_q[0] |=> !flg_q[0];
  endproperty
  a_no_false_set: assert property (p_no_false_set) else $error("32 Hz flag set without edge");

  property p_flag_keep;
    !fall_w[1] && !wr_iflg |=> $stable(flg_q[1]);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("8 Hz flag changed alone");

  property p_w1c_32hz;
    wr_iflg && I_PWDATA[0] && !fall_w[0] |=> !flg_q[0];
  endproperty
  a_w1c_32hz: assert property (p_w1c_32hz) else $error("32 Hz flag not cleared");

  property p_w0_keep;
    wr_iflg && !I_PWDATA[2] && flg_q[2] |=> flg_q[2];
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("2 Hz flag lost on zero write");

endmodule
`default_nettype wire

/* File: rtl/ctmr_defs.svh */
// Purpose: Constants of the clock timer block
// Assumes: 40 MHz reference clock
// Notes:   Register indices; byte address is four times the index
`ifndef CTMR_DEFS_SVH
`define CTMR_DEFS_SVH

`define CT_IDX_CTRL     16'hFF78
`define CT_IDX_LO       16'hFF79
`define CT_IDX_HI       16'hFF7A
`define CT_IDX_IEN      16'hFFE6
`define CT_IDX_IFLG     16'hFFF6

`define CT_CTRL_RUN_BIT 0
`define CT_CTRL_CLR_BIT 1

`define CT_RST_NIB      4'h0
`define CT_RST_RUN      1'b0

`define CT_CLK_HZ       40000000
`define CT_TICK_HZ      256
`define CT_TICK_CYC     (`CT_CLK_HZ / `CT_TICK_HZ)
`define CT_HOLD_NS      480000
`define CT_CLK_NS       25
`define CT_HOLD_CYC     ((`CT_HOLD_NS + `CT_CLK_NS - 1) / `CT_CLK_NS)

`endif

/* File: rtl/ctmr_pkg.sv */
// Purpose: Types of the clock timer block
// Assumes: Nothing
// Notes:   One-hot hold state
`default_nettype none
package ctmr_pkg;
  typedef enum logic [1:0] {
    CT_HOLD_OFF = 2'b01,
    CT_HOLD_ON  = 2'b10
  } ctmr_hold_t;
endpackage
`default_nettype wire

/* File: verif/clock_timer_with_interrupts_tb_top.sv */
// Purpose: Self-checking bench for the clock timer block over APB
// Assumes: Tick shortened to 8 cycles, hold window to 40 cycles
// Notes:   Count checks allow a small window; prescaler phase is not visible
`include "ctmr_defs.svh"
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module clock_timer_with_interrupts_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Hold must stay below sixteen ticks
  localparam logic [17:0] TICK = 18'h00008;
  localparam logic [17:0] HOLD = 18'h00028;
  localparam logic [15:0] IDX [5] = '{`CT_IDX_CTRL, `CT_IDX_LO, `CT_IDX_HI, `CT_IDX_IEN, `CT_IDX_IFLG};
  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [17:0] paddr     = 18'h00000;
  logic [31:0] pwdata    = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  v;
  logic [7:0]  held;
  int          fail_count = 0;
  int          tests_run  = 0;

  always #12.5 ref_clk = ~ref_clk;

  ctmr_top #(.TICK_CYC(TICK), .HOLD_CYC(HOLD)) i_dut (
    .I_REF_CLK(ref_clk), .I_RSTN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Request held until the edge that samples pready
  task apb(input logic w, input logic [15:0] idx, input logic [3:0] wd);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {28'h0000000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    `CHK(prdata[31:4], 28'h0);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [15:0] idx, input logic [3:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task rdr(input logic [15:0] idx);
    apb(1'b0, idx, 4'h0);
  endtask

  task rdcnt();
    rdr(`CT_IDX_LO);
    v[3:0] = rd[3:0];
    rdr(`CT_IDX_HI);
    v[7:4] = rd[3:0];
  endtask

  task t_reset();
    for (int i = 0; i < 5; i++) begin
      rdr(IDX[i]);
      `CHK(rd, 32'h0);
      `CHK(er, 1'b0);
    end
    rdr(16'hFF7B);
    `CHK(er, 1'b1);
    `CHK(rd, 32'h0);
    `CHK(irq, 1'b0);
    $display("test reset done");
  endtask

  task t_ctrl();
    wr(`CT_IDX_CTRL, 4'hF);
    rdr(`CT_IDX_CTRL);
    `CHK(rd, 32'h1);
    wr(`CT_IDX_CTRL, 4'h0);
    rdr(`CT_IDX_CTRL);
    `CHK(rd, 32'h0);
    $display("test control done");
  endtask

  task t_count();
    wr(`CT_IDX_CTRL, 4'h2);
    repeat (50) @(posedge ref_clk);
    rdcnt();
    `CHK(v, 8'h00);
    wr(`CT_IDX_CTRL, 4'h1);
    repeat (160) @(posedge ref_clk);
    wr(`CT_IDX_CTRL, 4'h3);
    rdcnt();
    `CHK(v <= 8'h01, 1'b1);
    repeat (160) @(posedge ref_clk);
    wr(`CT_IDX_CTRL, 4'h0);
    rdcnt();
    `CHK(v >= 8'h13 && v <= 8'h17, 1'b1);
    `CHK(v[7:4], 4'h1);
    held = v;
    wr(`CT_IDX_LO, 4'hF);
    wr(`CT_IDX_HI, 4'hF);
    repeat (100) @(posedge ref_clk);
    rdcnt();
    `CHK(v, held);
    wr(`CT_IDX_CTRL, 4'h1);
    repeat (40) @(posedge ref_clk);
    wr(`CT_IDX_CTRL, 4'h0);
    rdcnt();
    `CHK(v >= held + 8'h04 && v <= held + 8'h07, 1'b1);
    $display("test count done");
  endtask

  task pollf();
    int n;
    n = 0;
    do begin
      rdr(`CT_IDX_LO);
      n++;
    end while (rd[3:0] !== 4'hF && n < 100);
    `CHK(rd[3:0], 4'hF);
  endtask

  task t_hold();
    wr(`CT_IDX_CTRL, 4'h3);
    pollf();
    repeat (10) @(posedge ref_clk);
    rdr(`CT_IDX_HI);
    `CHK(rd, 32'h0);
    rdr(`CT_IDX_HI);
    `CHK(rd, 32'h1);
    pollf();
    repeat (60) @(posedge ref_clk);
    rdr(`CT_IDX_HI);
    `CHK(rd, 32'h2);
    wr(`CT_IDX_CTRL, 4'h0);
    $display("test hold done");
  endtask

  task t_irq();
    wr(`CT_IDX_CTRL, 4'h2);
    wr(`CT_IDX_IFLG, 4'hF);
    rdr(`CT_IDX_IFLG);
    `CHK(rd, 32'h0);
    wr(`CT_IDX_CTRL, 4'h1);
    // Past one full wrap so the slowest tap falls too
    repeat (2100) @(posedge ref_clk);
    wr(`CT_IDX_CTRL, 4'h0);
    rdr(`CT_IDX_IFLG);
    `CHK(rd, 32'hF);
    repeat (3) @(posedge ref_clk);
    `CHK(irq, 1'b0);
    wr(`CT_IDX_IEN, 4'h2);
    rdr(`CT_IDX_IEN);
    `CHK(rd, 32'h2);
    repeat (3) @(posedge ref_clk);
    `CHK(irq, 1'b1);
    wr(`CT_IDX_IFLG, 4'hD);
    rdr(`CT_IDX_IFLG);
    `CHK(rd, 32'h2);
    `CHK(irq, 1'b1);
    wr(`CT_IDX_IFLG, 4'h0);
    rdr(`CT_IDX_IFLG);
    `CHK(rd, 32'h2);
    wr(`CT_IDX_IFLG, 4'h2);
    repeat (3) @(posedge ref_clk);
    `CHK(irq, 1'b0);
    rdr(`CT_IDX_IFLG);
    `CHK(rd, 32'h0);
    wr(`CT_IDX_IEN, 4'h0);
    $display("test interrupt done");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_ctrl();
    t_count();
    t_hold();
    t_irq();
    final_report();
  end

  // Tests need about 3100 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
